/* ats_pkg.sv */
// Package for the analyzer timing and converter sequencer block.
// Assumes a single 11.0592 MHz master clock drives the block.
package ats_pkg;
    // Master clock rate in Hz
    localparam int unsigned MASTER_CLOCK_HZ = 11_059_200;
    // Divider chain length, fourteen binary stages
    localparam int DIV_STAGES = 14;
    // Divider tap positions (bit n divides by 2^(n+1))
    localparam int TAP_RF = 1;
    localparam int TAP_SYNC = 5;
    localparam int TAP_SUPPLY = 6;
    localparam int TAP_HV = 7;
    localparam int TAP_CONVERT = 13;
    // Sync pulse width in ns and derived cycle count, rounded up
    localparam int unsigned SYNC_PULSE_NS = 100;
    localparam int unsigned SYNC_PULSE_CYCLES =
        (SYNC_PULSE_NS * (MASTER_CLOCK_HZ / 1000) + 999_999) / 1_000_000;
    // Port width
    localparam int PORT_W = 8;
    localparam logic [7:0] PORT_RESET = 8'h00;
    // Indicator port field positions
    localparam int IND_LOG_STROBE = 4;
    // Analog select port fields
    localparam int ASEL_CAL_LSB = 0;
    localparam int ASEL_CHAN_LSB = 3;
    localparam int ASEL_FIL_REG = 6;
    localparam int ASEL_GRID = 7;
    // Relay control port fields
    localparam int RLY_RF_DRIVE_ENABLE = 0;
    localparam int RLY_IONS_GND = 1;
    localparam int RLY_IONS_CONN = 2;
    localparam int RLY_MULT_GND = 3;
    localparam int RLY_MULT_CONN = 4;
    localparam int RLY_LINEAR = 5;
    localparam int RLY_READ_CONV = 6;
    localparam int RLY_VETO = 7;
endpackage

/* ats_sequencer.sv */
// Timing dividers, drive gating, output ports and converter sequencing.
// Assumes SPI and strobes come from a controller in another clock domain
// and are synchronised here; the master clock runs continuously.
//
// Summary of operation
// - Divide master clock by four for RF
// - Divide by 128 supply, 256 high voltage
// - Fourteen stage divider gives 675 Hz convert
// - Shape 172.8 kHz into two-cycle pulse, 100 ns rounded up
// - Complementary drive pairs, both high when disabled
// - Indicator bits light lamps, except bit four
// - Indicator bit four strobes log mode
// - Analog bits 0..2 select calibration attenuator
// - Analog bits 3..5 select converter channel
// - Bit six filament regulate, seven grid
// - Relay bit zero enables RF drive
// - Relay bit six is read/convert
// - Relay bit seven vetoes chip select
// - Chip select falls with start clock unless vetoed
// - Start clock fall raises interrupt request
// - Converter data clock is inverted SPI clock
// - Reset clears conditioning pair; second strobe sets
// - Conditioning low forces safe analog states
// - SPI shift register, load strobe copies
// - Busy low during conversion
`timescale 1ns/1ps
module ats_sequencer
    import ats_pkg::*;
(
    input wire logic I_CLOCK,
    input wire logic I_ARST_N,
    input wire logic I_SPI_CLK,
    input wire logic I_SPI_MOSI,
    input wire logic I_INDICATOR_LOAD_STROBE,
    input wire logic I_ANALOG_SELECT_LOAD_STROBE,
    input wire logic I_RELAY_CONTROL_LOAD_STROBE,
    input wire logic I_CONVERTER_BUSY_N,
    output logic O_RF_CLOCK,
    output logic O_SUPPLY_CLOCK,
    output logic O_HV_CLOCK,
    output logic O_CONVERT_CLOCK,
    output logic O_SUPPLY_SYNC,
    input wire logic I_HV_DRIVE_ENABLE,
    output logic O_RF_DRIVE_A,
    output logic O_RF_DRIVE_B,
    output logic O_HV_DRIVE_A,
    output logic O_HV_DRIVE_B,
    output logic [7:0] O_INDICATOR_PORT,
    output logic [7:0] O_ANALOG_SELECT_PORT,
    output logic [7:0] O_RELAY_CONTROL_PORT,
    output logic [2:0] O_CAL_ATTEN_SEL,
    output logic O_ADC_CHAN_SEL_BIT0,
    output logic O_ADC_CHAN_SEL_BIT1,
    output logic O_ADC_CHAN_SEL_BIT2,
    output logic O_FILAMENT_REGULATE_SEL,
    output logic O_GRID_HIGH_SEL,
    output logic O_LOG_MODE_STROBE,
    output logic O_RF_DRIVE_ENABLE,
    output logic O_READ_CONVERT,
    output logic O_CHIP_SELECT_VETO,
    output logic O_CONVERTER_SELECT_N,
    output logic O_IRQ_N,
    output logic O_CONVERTER_DATA_CLK,
    output logic O_CONVERTER_BUSY,
    output logic O_SAFE_STATE_RELEASE,
    output logic O_REF_ENABLE,
    output logic O_RF_DAC_SHUNT
);

    // Whole module state in one packed struct
    typedef struct packed {
        logic [DIV_STAGES-1:0] div;     // Binary divider chain
        logic [1:0] spi_clk_s;          // SPI clock synchroniser
        logic spi_clk_prev;             // Edge detect on synced clock
        logic [1:0] mosi_s;             // SPI data synchroniser
        logic [2:0] ld_ind_s;           // Indicator strobe sync + prev
        logic [2:0] ld_asel_s;          // Analog strobe sync + prev
        logic [2:0] ld_rly_s;           // Relay strobe sync + prev
        logic [1:0] busy_s;             // Busy synchroniser
        logic [1:0] hv_en_s;            // HV enable synchroniser
        logic [7:0] shift;              // SPI shift register
        logic [7:0] ind;                // Indicator output register
        logic [7:0] asel;               // Analog select output register
        logic [7:0] rly;                // Relay control output register
        logic [1:0] cond;               // Conditioning flip-flop pair
        logic [3:0] sync_cnt;           // Sync pulse width counter
        logic irq_n;                    // Interrupt request, active low
        logic cs_n;                     // Converter chip select
        logic rf_a;                     // RF drive phase
        logic hv_a;                     // HV drive phase
    } ats_state_type;

    ats_state_type st_q;
    ats_state_type st_d;

    localparam logic [3:0] SYNC_LEN = 4'(SYNC_PULSE_CYCLES);

    // Edge and strobe helpers from synced stages and the divider
    logic spi_rise;
    logic ind_ld;
    logic asel_ld;
    logic rly_ld;
    logic sync_rise;

    // Next-state logic
    always_comb begin
        st_d = st_q;
        // Synchronisers, first stage read only by second
        st_d.spi_clk_s = {st_q.spi_clk_s[0], I_SPI_CLK};
        st_d.spi_clk_prev = st_q.spi_clk_s[1];
        st_d.mosi_s = {st_q.mosi_s[0], I_SPI_MOSI};
        st_d.ld_ind_s = {st_q.ld_ind_s[1:0], I_INDICATOR_LOAD_STROBE};
        st_d.ld_asel_s = {st_q.ld_asel_s[1:0], I_ANALOG_SELECT_LOAD_STROBE};
        st_d.ld_rly_s = {st_q.ld_rly_s[1:0], I_RELAY_CONTROL_LOAD_STROBE};
        st_d.busy_s = {st_q.busy_s[0], I_CONVERTER_BUSY_N};
        st_d.hv_en_s = {st_q.hv_en_s[0], I_HV_DRIVE_ENABLE};
        // Free-running divider chain
        st_d.div = st_q.div + 1'b1;
        spi_rise = st_q.spi_clk_s[1] & ~st_q.spi_clk_prev;
        ind_ld = st_q.ld_ind_s[1] & ~st_q.ld_ind_s[2];
        asel_ld = st_q.ld_asel_s[1] & ~st_q.ld_asel_s[2];
        rly_ld = st_q.ld_rly_s[1] & ~st_q.ld_rly_s[2];
        sync_rise = ~st_q.div[TAP_SYNC] & st_d.div[TAP_SYNC];
        // Shift SPI data in, MSB first, on rising SPI clock
        if (spi_rise) begin
            st_d.shift = {st_q.shift[6:0], st_q.mosi_s[1]};
        end
        // Load strobes copy shift register to ports
        if (ind_ld) begin
            st_d.ind = st_q.shift;
        end
        if (asel_ld) begin
            st_d.asel = st_q.shift;
        end
        if (rly_ld) begin
            st_d.rly = st_q.shift;
            // Conditioning pair clocks on relay strobes
            st_d.cond = {st_q.cond[0], 1'b1};
        end
        // Sync pulse shaping once per 172.8 kHz period
        if (sync_rise) begin
            st_d.sync_cnt = SYNC_LEN;
        end else if (st_q.sync_cnt != 4'h0) begin
            st_d.sync_cnt = st_q.sync_cnt - 4'h1;
        end
        // Interrupt: raised on start clock fall, held for that low half
        st_d.irq_n = st_d.div[TAP_CONVERT];
        // Chip select low through the start clock low half unless vetoed;
        // dropping the veto reselects the converter for the data read
        st_d.cs_n = st_q.rly[RLY_VETO] | st_d.div[TAP_CONVERT];
        // Drive phases follow divider taps
        st_d.rf_a = st_d.div[TAP_RF];
        st_d.hv_a = st_d.div[TAP_HV];
    end

    // State register
    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            st_q <= '0;
            st_q.irq_n <= 1'b1;
            st_q.cs_n <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // Clock outputs from divider taps
    assign O_RF_CLOCK = st_q.div[TAP_RF];
    assign O_SUPPLY_CLOCK = st_q.div[TAP_SUPPLY];
    assign O_HV_CLOCK = st_q.div[TAP_HV];
    assign O_CONVERT_CLOCK = st_q.div[TAP_CONVERT];
    assign O_SUPPLY_SYNC = (st_q.sync_cnt != 4'h0);

    // Complementary drives, forced high when disabled
    assign O_RF_DRIVE_A = st_q.rf_a | ~st_q.rly[RLY_RF_DRIVE_ENABLE];
    assign O_RF_DRIVE_B = ~st_q.rf_a | ~st_q.rly[RLY_RF_DRIVE_ENABLE];
    assign O_HV_DRIVE_A = st_q.hv_a | ~st_q.hv_en_s[1];
    assign O_HV_DRIVE_B = ~st_q.hv_a | ~st_q.hv_en_s[1];

    // Port registers and decoded fields
    assign O_INDICATOR_PORT = st_q.ind;
    assign O_LOG_MODE_STROBE = st_q.ind[IND_LOG_STROBE];
    assign O_ANALOG_SELECT_PORT = st_q.asel;
    assign O_CAL_ATTEN_SEL = st_q.asel[ASEL_CAL_LSB +: 3];
    assign O_ADC_CHAN_SEL_BIT0 = st_q.asel[ASEL_CHAN_LSB];
    assign O_ADC_CHAN_SEL_BIT1 = st_q.asel[ASEL_CHAN_LSB + 1];
    assign O_ADC_CHAN_SEL_BIT2 = st_q.asel[ASEL_CHAN_LSB + 2];
    // Filament direct while conditioning is cleared
    assign O_FILAMENT_REGULATE_SEL =
        st_q.asel[ASEL_FIL_REG] & st_q.cond[1];
    assign O_GRID_HIGH_SEL = st_q.asel[ASEL_GRID];
    assign O_RELAY_CONTROL_PORT = st_q.rly;
    assign O_RF_DRIVE_ENABLE = st_q.rly[RLY_RF_DRIVE_ENABLE];
    assign O_READ_CONVERT = st_q.rly[RLY_READ_CONV];
    assign O_CHIP_SELECT_VETO = st_q.rly[RLY_VETO];

    // Converter sequencing outputs
    assign O_CONVERTER_SELECT_N = st_q.cs_n;
    assign O_IRQ_N = st_q.irq_n;
    assign O_CONVERTER_DATA_CLK = ~I_SPI_CLK;
    assign O_CONVERTER_BUSY = ~st_q.busy_s[1];

    // Safe state controls
    assign O_SAFE_STATE_RELEASE = st_q.cond[1];
    assign O_REF_ENABLE = st_q.cond[1];
    assign O_RF_DAC_SHUNT = ~st_q.cond[1];

    // Assertions
    sequence s_conv_fall;
        $fell(st_q.div[TAP_CONVERT]);
    endsequence

    property p_rf_div;
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        $rose(O_RF_CLOCK) |-> ##4 $rose(O_RF_CLOCK);
    endproperty
    a_rf_div: assert property (p_rf_div) else $error("rf period");

    property p_hv_div;
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        $rose(O_HV_CLOCK) |-> ##256 $rose(O_HV_CLOCK);
    endproperty
    a_hv_div: assert property (p_hv_div) else $error("hv period");

    property p_sync_width;
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        $rose(O_SUPPLY_SYNC) |-> O_SUPPLY_SYNC [*2] ##1 !O_SUPPLY_SYNC;
    endproperty
    a_sync_width: assert property (p_sync_width) else $error("sync");

    property p_rf_off;
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        !O_RF_DRIVE_ENABLE |-> O_RF_DRIVE_A && O_RF_DRIVE_B;
    endproperty
    a_rf_off: assert property (p_rf_off) else $error("rf off");

    property p_irq;
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        s_conv_fall |-> ##1 !O_IRQ_N;
    endproperty
    a_irq: assert property (p_irq) else $error("irq");

    property p_cs;
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        s_conv_fall ##0 !O_CHIP_SELECT_VETO ##1 !O_CHIP_SELECT_VETO
        |=> !O_CONVERTER_SELECT_N;
    endproperty
    a_cs: assert property (p_cs) else $error("cs");

    property p_veto;
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        O_CHIP_SELECT_VETO |=> O_CONVERTER_SELECT_N;
    endproperty
    a_veto: assert property (p_veto) else $error("veto");

    property p_safe;
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        !O_SAFE_STATE_RELEASE |-> O_RF_DAC_SHUNT && !O_FILAMENT_REGULATE_SEL;
    endproperty
    a_safe: assert property (p_safe) else $error("safe");

    property p_load;
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        $rose(st_q.ld_ind_s[1]) |=> O_INDICATOR_PORT == $past(st_q.shift);
    endproperty
    a_load: assert property (p_load) else $error("load");

    property p_rly_load;
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        $rose(st_q.ld_rly_s[1]) |=>
            O_RELAY_CONTROL_PORT == $past(st_q.shift);
    endproperty
    a_rly_load: assert property (p_rly_load) else $error("rly load");

    property p_supply_div;
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        $rose(O_SUPPLY_CLOCK) |-> ##128 $rose(O_SUPPLY_CLOCK);
    endproperty
    a_supply_div: assert property (p_supply_div) else $error("supply");

    // Veto released while the start clock is still low
    sequence s_veto_open;
        !O_CHIP_SELECT_VETO ##1 !O_CONVERT_CLOCK;
    endsequence

    property p_reselect;
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        s_veto_open |-> !O_CONVERTER_SELECT_N;
    endproperty
    a_reselect: assert property (p_reselect) else $error("reselect");

    property p_release;
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        $rose(O_SAFE_STATE_RELEASE) |-> $past(rly_ld) && $past(st_q.cond[0]);
    endproperty
    a_release: assert property (p_release) else $error("release");

    property p_busy;
        @(posedge I_CLOCK) disable iff (!I_ARST_N)
        $fell(I_CONVERTER_BUSY_N) |-> ##2 O_CONVERTER_BUSY;
    endproperty
    a_busy: assert property (p_busy) else $error("busy");

endmodule

/* ats_host.sv */
// Controller model: shifts port bytes over SPI, strobes loads, and
// plays the converter busy line. Assumes master clock on i_clock.
`timescale 1ns/1ps
module ats_host (
    input wire logic i_clock,
    input wire logic i_cs_n,
    input wire logic i_read_convert,
    output logic o_spi_clk,
    output logic o_mosi,
    output logic [2:0] o_load,
    output logic o_busy_n
);
    // Converter busy span in master cycles, a plain stand-in
    localparam int BUSY_CYCLES = 20;
    // Idle levels
    initial begin
        o_spi_clk = 1'b0;
        o_mosi = 1'b0;
        o_load = 3'h0;
        o_busy_n = 1'b1;
    end
    // Busy low while converting, only when started with read low
    always @(negedge i_cs_n) begin
        if (i_read_convert === 1'b0) begin
            #2 o_busy_n = 1'b0;
            repeat (BUSY_CYCLES) @(posedge i_clock);
            #2 o_busy_n = 1'b1;
        end
    end
    // Shift a byte MSB first, then strobe the port load
    task automatic load(input int port, input logic [7:0] v);
        for (int b = 7; b >= 0; b--) begin
            @(posedge i_clock);
            #2 o_mosi = v[b];
            repeat (4) @(posedge i_clock);
            #2 o_spi_clk = 1'b1;
            repeat (4) @(posedge i_clock);
            #2 o_spi_clk = 1'b0;
        end
        // Data line no longer holds the last bit
        o_mosi = ~v[0];
        repeat (4) @(posedge i_clock);
        #2 o_load[port] = 1'b1;
        repeat (4) @(posedge i_clock);
        #2 o_load[port] = 1'b0;
        repeat (8) @(posedge i_clock);
        // Hand back just after an edge, off the sampling point
        #2;
    endtask
endmodule

/* analyzer_timing_and_adc_sequencer_bench.sv */
// Self-checking bench for the timing and converter sequencer.
// Assumes the controller model drives SPI, strobes and busy.
`timescale 1ns/1ps
module analyzer_timing_and_adc_sequencer_bench;
    import ats_pkg::*;
    // Design inputs and outputs
    logic I_CLOCK, I_ARST_N, I_HV_DRIVE_ENABLE;
    logic I_SPI_CLK, I_SPI_MOSI, I_CONVERTER_BUSY_N;
    logic [2:0] ld;
    logic O_RF_CLOCK, O_SUPPLY_CLOCK, O_HV_CLOCK, O_CONVERT_CLOCK;
    logic O_SUPPLY_SYNC, O_RF_DRIVE_A, O_RF_DRIVE_B, O_HV_DRIVE_A;
    logic O_HV_DRIVE_B, O_ADC_CHAN_SEL_BIT0, O_ADC_CHAN_SEL_BIT1;
    logic O_ADC_CHAN_SEL_BIT2, O_FILAMENT_REGULATE_SEL, O_GRID_HIGH_SEL;
    logic O_LOG_MODE_STROBE, O_RF_DRIVE_ENABLE, O_READ_CONVERT;
    logic O_CHIP_SELECT_VETO, O_CONVERTER_SELECT_N, O_IRQ_N;
    logic O_CONVERTER_DATA_CLK, O_CONVERTER_BUSY, O_SAFE_STATE_RELEASE;
    logic O_REF_ENABLE, O_RF_DAC_SHUNT;
    logic [7:0] O_INDICATOR_PORT, O_ANALOG_SELECT_PORT;
    logic [7:0] O_RELAY_CONTROL_PORT;
    logic [2:0] O_CAL_ATTEN_SEL;
    int fails = 0;
    int n_compared = 0;
    // Master clock, 20 ns period
    always #10 I_CLOCK = ~I_CLOCK;
    ats_sequencer ats_sequencer_i (.I_CLOCK, .I_ARST_N, .I_SPI_CLK,
        .I_SPI_MOSI, .I_INDICATOR_LOAD_STROBE(ld[0]),
        .I_ANALOG_SELECT_LOAD_STROBE(ld[1]),
        .I_RELAY_CONTROL_LOAD_STROBE(ld[2]), .I_CONVERTER_BUSY_N,
        .O_RF_CLOCK, .O_SUPPLY_CLOCK, .O_HV_CLOCK, .O_CONVERT_CLOCK,
        .O_SUPPLY_SYNC, .I_HV_DRIVE_ENABLE, .O_RF_DRIVE_A, .O_RF_DRIVE_B,
        .O_HV_DRIVE_A, .O_HV_DRIVE_B, .O_INDICATOR_PORT,
        .O_ANALOG_SELECT_PORT, .O_RELAY_CONTROL_PORT, .O_CAL_ATTEN_SEL,
        .O_ADC_CHAN_SEL_BIT0, .O_ADC_CHAN_SEL_BIT1, .O_ADC_CHAN_SEL_BIT2,
        .O_FILAMENT_REGULATE_SEL, .O_GRID_HIGH_SEL, .O_LOG_MODE_STROBE,
        .O_RF_DRIVE_ENABLE, .O_READ_CONVERT, .O_CHIP_SELECT_VETO,
        .O_CONVERTER_SELECT_N, .O_IRQ_N, .O_CONVERTER_DATA_CLK,
        .O_CONVERTER_BUSY, .O_SAFE_STATE_RELEASE, .O_REF_ENABLE,
        .O_RF_DAC_SHUNT);
    ats_host ats_host_i (.i_clock(I_CLOCK), .i_cs_n(O_CONVERTER_SELECT_N),
        .i_read_convert(O_READ_CONVERT), .o_spi_clk(I_SPI_CLK),
        .o_mosi(I_SPI_MOSI), .o_load(ld), .o_busy_n(I_CONVERTER_BUSY_N));
    // Compare and count
    task automatic chk(input string what, input logic [15:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Converter data clock must be low while the SPI clock is high
    always @(posedge I_SPI_CLK) begin
        #1 chk("data clk high", 0, O_CONVERTER_DATA_CLK);
    end
    // Divided clock selector
    function automatic logic pick(input int k);
        case (k)
            0: return O_RF_CLOCK;
            1: return O_SUPPLY_CLOCK;
            2: return O_HV_CLOCK;
            3: return O_CONVERT_CLOCK;
            default: return O_SUPPLY_SYNC;
        endcase
    endfunction
    // Period and high time of one selected output, from a rise
    task automatic t_period(input int k, input int per_x, hi_x);
        int per, hi;
        logic prev, rise;
        per = 0;
        hi = 0;
        // Start high so a level already high is not taken as a rise
        prev = 1'b1;
        rise = 1'b0;
        while (!rise && per < 40000) begin
            @(posedge I_CLOCK);
            #1 rise = pick(k) && !prev;
            prev = pick(k);
            per++;
        end
        per = 0;
        rise = 1'b0;
        while (!rise && per < 40000) begin
            hi += prev;
            @(posedge I_CLOCK);
            #1 rise = pick(k) && !prev;
            prev = pick(k);
            per++;
        end
        chk($sformatf("period %0d", k), per_x, per);
        chk($sformatf("high %0d", k), hi_x, hi);
    endtask
    // Wait for the next falling edge of the interrupt request
    task automatic wait_irq();
        int n = 0;
        while (O_IRQ_N !== 1'b1 && n < 40000) begin
            @(posedge I_CLOCK);
            #1 n++;
        end
        while (O_IRQ_N !== 1'b0 && n < 40000) begin
            @(posedge I_CLOCK);
            #1 n++;
        end
        chk("irq_n", 0, O_IRQ_N);
    endtask
    // Verdict and end of run
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Watchdog: the run needs about 50000 cycles, three start periods
    initial begin
        repeat (80000) @(posedge I_CLOCK);
        fails++;
        conclude();
    end
    // Main sequence
    initial begin
        I_CLOCK = 1'b0;
        I_ARST_N = 1'b0;
        I_HV_DRIVE_ENABLE = 1'b0;
        repeat (8) @(posedge I_CLOCK);
        chk("ports", 16'h0, {O_INDICATOR_PORT, O_RELAY_CONTROL_PORT});
        chk("asel port", 8'h00, O_ANALOG_SELECT_PORT);
        chk("rf pair", 2'b11, {O_RF_DRIVE_A, O_RF_DRIVE_B});
        chk("cs irq", 2'b11, {O_CONVERTER_SELECT_N, O_IRQ_N});
        chk("shunt safe", 2'b10, {O_RF_DAC_SHUNT, O_REF_ENABLE});
        #2 I_ARST_N = 1'b1;
        t_period(0, 4, 2);
        t_period(1, 128, 64);
        t_period(2, 256, 128);
        t_period(3, 16384, 8192);
        t_period(4, 64, SYNC_PULSE_CYCLES);
        ats_host_i.load(0, 8'hEF);
        chk("indicator", 8'hEF, O_INDICATOR_PORT);
        chk("log", 0, O_LOG_MODE_STROBE);
        ats_host_i.load(0, 8'h10);
        chk("log", 1, O_LOG_MODE_STROBE);
        ats_host_i.load(1, 8'hE9);
        chk("cal", 3'h1, O_CAL_ATTEN_SEL);
        chk("asel", 8'hE9, O_ANALOG_SELECT_PORT);
        chk("chan", 3'h5, {O_ADC_CHAN_SEL_BIT2, O_ADC_CHAN_SEL_BIT1,
            O_ADC_CHAN_SEL_BIT0});
        chk("fil grid", 2'b01,
            {O_FILAMENT_REGULATE_SEL, O_GRID_HIGH_SEL});
        ats_host_i.load(2, 8'h01);
        chk("release1", 0, O_SAFE_STATE_RELEASE);
        chk("rf en", 1, O_RF_DRIVE_ENABLE);
        chk("rf cpl", 1, O_RF_DRIVE_A ^ O_RF_DRIVE_B);
        I_HV_DRIVE_ENABLE = 1'b1;
        ats_host_i.load(2, 8'h3E);
        chk("relay", 8'h3E, O_RELAY_CONTROL_PORT);
        chk("release2", 3'b110, {O_SAFE_STATE_RELEASE, O_REF_ENABLE,
            O_RF_DAC_SHUNT});
        chk("fil reg", 1, O_FILAMENT_REGULATE_SEL);
        chk("rf off", 2'b11, {O_RF_DRIVE_A, O_RF_DRIVE_B});
        chk("hv cpl", 1, O_HV_DRIVE_A ^ O_HV_DRIVE_B);
        I_HV_DRIVE_ENABLE = 1'b0;
        ats_host_i.load(2, 8'h00);
        chk("hv off", 2'b11, {O_HV_DRIVE_A, O_HV_DRIVE_B});
        chk("data clk", 1, O_CONVERTER_DATA_CLK);
        wait_irq();
        chk("cs start", 0, O_CONVERTER_SELECT_N);
        repeat (6) @(posedge I_CLOCK);
        chk("busy", 1, O_CONVERTER_BUSY);
        ats_host_i.load(2, 8'hC0);
        chk("veto cs", 3'b111, {O_CONVERTER_SELECT_N, O_CHIP_SELECT_VETO,
            O_READ_CONVERT});
        chk("busy done", 0, O_CONVERTER_BUSY);
        ats_host_i.load(2, 8'h40);
        chk("cs reselect", 0, O_CONVERTER_SELECT_N);
        wait_irq();
        chk("cs read", 0, O_CONVERTER_SELECT_N);
        repeat (6) @(posedge I_CLOCK);
        chk("no conv", 0, O_CONVERTER_BUSY);
        ats_host_i.load(2, 8'h00);
        chk("rc low", 0, O_READ_CONVERT);
        conclude();
    end
endmodule
